// ### src/divided_pwm.sv
// top: divided pwm generator with selectable ratio, clamps and polarity
`timescale 1ns/1ns
// Function
// - the 4-bit selector code alone picks division ratio and polarity
// - selector top bit set inverts the pwm wave before the output
// - output period is 256 times ratio master periods, ratio 1 to 64
// - codes 0..7 non-inverted, ratio four times larger per code, back to 1 at code 4
// - codes 8..15 inverted, ratio mirrored, 64 down to 1 over codes 8..11 and again over 12..15
// - master tick rate is at most 1MHz, set externally
// - duty follows modulation level linearly across the middle range
// - outside range duty clamps at 5%/95% or stops, by variant
// - oscillation stops when the programming current is too low
// - output low for 500 master periods after reset, then first pulse correct
// - new code adopted only after filter says stable, no glitches
// - unclamped ends stop oscillation, output held low or high
module divided_pwm
   import pwm_pkg::*;
#(
   parameter logic [2:0] VARIANT = VARIANT_FULL,
   parameter int START_CNT = START_TICKS,
   parameter int FILTER_CNT = FILTER_TICKS
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst_n,
   // master oscillator tick, one-cycle enable, at most 1MHz
   input wire logic i_master_tick,
   // programming current adequate; low stops oscillation
   input wire logic i_current_ok,
   // settings
   input wire logic [CODE_W-1:0] i_ratio_selector_code,
   input wire logic [DUTY_W-1:0] i_duty_control_input,
   // pwm output and status
   output logic o_pwm,
   output logic o_running,
   output logic [CODE_W-1:0] o_active_code
);
   logic rst_s1_reg, rst_s2_reg, rst;
   logic [CODE_W-1:0] code_filt;
   sel_t sel;
   run_state_t state_reg, state_next;
   logic [9:0] start_reg, start_next;
   logic [PRESC_W-1:0] presc_reg, presc_next;
   logic [DUTY_W-1:0] phase_reg, phase_next, thr_reg, thr_next, thr_calc;
   logic [CODE_W-1:0] code_reg, code_next;
   logic pwm_reg, pwm_next, run_reg, run_next;
   logic step, wrap, raw;

   // reset release through two flops so deassertion is clean
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst = !rst_s2_reg;

   code_filter #(.HOLD(FILTER_CNT)) u_filter (
      .i_clock(i_clock),
      .i_rst(rst),
      .i_tick(i_master_tick),
      .i_code(i_ratio_selector_code),
      .i_load(state_reg == ST_START),
      .o_code(code_filt)
   );

   // decode: top bit is polarity, ratio exponent mirrored for inverted codes
   always_comb begin
      sel.invert = code_reg[INV_BIT];
      sel.ratio_exp = code_reg[INV_BIT] ? (RATIO_MAX - code_reg[2:0]) : code_reg[2:0];
   end

   // one step of the duty counter every 4^(exp mod 4) master ticks, the shift amount product being 3 bits wide
   assign step = i_master_tick && i_current_ok &&
      (presc_reg == PRESC_ZERO);
   assign wrap = step && (phase_reg == DUTY_FULL);

   // linear map with clamps; clamps come before polarity
   always_comb begin
      if (i_duty_control_input <= DUTY_LO_OFS) begin
         thr_calc = DUTY_ZERO;
      end else if (i_duty_control_input >= DUTY_HI_OFS) begin
         thr_calc = DUTY_FULL;
      end else begin
         thr_calc = 8'((10'(i_duty_control_input - DUTY_LO_OFS) * 10'd5) >> 2);
      end
      if ((VARIANT == VARIANT_BOTH || VARIANT == VARIANT_LOW) && thr_calc < CLAMP_LO) begin
         thr_calc = CLAMP_LO;
      end
      if ((VARIANT == VARIANT_BOTH || VARIANT == VARIANT_HIGH) && thr_calc > CLAMP_HI) begin
         thr_calc = CLAMP_HI;
      end
   end

   // compare count against threshold; full threshold means always high
   assign raw = (thr_reg == DUTY_FULL) ? 1'b1 : (phase_reg < thr_reg);

   always_comb begin
      state_next = state_reg;
      start_next = start_reg;
      presc_next = presc_reg;
      phase_next = phase_reg;
      thr_next = thr_reg;
      code_next = code_reg;
      pwm_next = pwm_reg;
      run_next = run_reg;
      case (state_reg)
         ST_START: begin
            pwm_next = 1'b0;
            code_next = code_filt;
            thr_next = thr_calc;
            presc_next = PRESC_ZERO;
            phase_next = DUTY_ZERO;
            if (i_master_tick) begin
               if (start_reg == 10'(START_CNT - 1)) begin
                  state_next = ST_RUN;
                  run_next = 1'b1;
               end else begin
                  start_next = start_reg + 10'h001;
               end
            end
         end
         ST_RUN: begin
            if (i_master_tick && i_current_ok) begin
               if (presc_reg == PRESC_ZERO) begin
                  presc_next = PRESC_W'((15'h0001 << (RATIO_STEP * sel.ratio_exp)) - 15'h0001);
               end else begin
                  presc_next = presc_reg - 14'h0001;
               end
            end
            if (step) begin
               phase_next = phase_reg + 8'h01;
            end
            if (wrap) begin
               thr_next = thr_calc;
               code_next = code_filt;
            end
            pwm_next = raw ^ sel.invert;
         end
         default: begin
            state_next = ST_START;
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge rst) begin
      if (rst) begin
         state_reg <= ST_START;
         start_reg <= 10'h000;
         presc_reg <= PRESC_ZERO;
         phase_reg <= DUTY_ZERO;
         thr_reg <= DUTY_ZERO;
         code_reg <= 4'h0;
         pwm_reg <= 1'b0;
         run_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         start_reg <= start_next;
         presc_reg <= presc_next;
         phase_reg <= phase_next;
         thr_reg <= thr_next;
         code_reg <= code_next;
         pwm_reg <= pwm_next;
         run_reg <= run_next;
      end
   end

   // status copies the registered run flag and adopted code
   assign o_pwm = pwm_reg;
   assign o_running = run_reg;
   assign o_active_code = code_reg;
endmodule

// ### src/pwm_pkg.sv
// package: constants and carrier types for the divided pwm generator
package pwm_pkg;
   localparam int CODE_W = 4;
   localparam int DUTY_W = 8;
   localparam int PRESC_W = 14;
   localparam int INV_BIT = 3;
   localparam int START_TICKS = 500;
   localparam int FILTER_TICKS = 16;
   localparam logic [PRESC_W-1:0] PRESC_ZERO = 14'h0000;
   localparam logic [DUTY_W-1:0] DUTY_ZERO = 8'h00;
   localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hFF;
   localparam logic [DUTY_W-1:0] DUTY_LO_OFS = 8'h1A;
   localparam logic [DUTY_W-1:0] DUTY_HI_OFS = 8'hE6;
   localparam logic [DUTY_W-1:0] CLAMP_LO = 8'h0D;
   localparam logic [DUTY_W-1:0] CLAMP_HI = 8'hF2;
   localparam logic [2:0] RATIO_MAX = 3'h7;
   localparam logic [1:0] RATIO_STEP = 2'h2;
   localparam logic [2:0] VARIANT_FULL = 3'h0;
   localparam logic [2:0] VARIANT_BOTH = 3'h1;
   localparam logic [2:0] VARIANT_HIGH = 3'h2;
   localparam logic [2:0] VARIANT_LOW = 3'h3;
   typedef enum logic [1:0] {ST_START = 2'b00, ST_RUN = 2'b01} run_state_t;
   typedef struct packed {
      logic invert;
      logic [2:0] ratio_exp;
   } sel_t;
endpackage

// ### src/code_filter.sv
// stability filter that adopts a new selector code only once it has held
`timescale 1ns/1ns
module code_filter
   import pwm_pkg::*;
#(
   parameter int HOLD = FILTER_TICKS
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // sampling
   input wire logic i_tick,
   input wire logic [CODE_W-1:0] i_code,
   input wire logic i_load,
   // filtered code
   output logic [CODE_W-1:0] o_code
);
   logic [CODE_W-1:0] cand_reg, cand_next, code_reg, code_next;
   logic [7:0] cnt_reg, cnt_next;

   // candidate must hold for the whole window, so a sweeping level never lands mid-way
   always_comb begin
      cand_next = cand_reg;
      cnt_next = cnt_reg;
      code_next = code_reg;
      if (i_load) begin
         code_next = i_code;
         cand_next = i_code;
         cnt_next = 8'h00;
      end else if (i_tick) begin
         if (i_code != cand_reg) begin
            cand_next = i_code;
            cnt_next = 8'h00;
         end else if (cnt_reg < 8'(HOLD)) begin
            cnt_next = cnt_reg + 8'h01;
         end else begin
            code_next = cand_reg;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         cand_reg <= 4'h0;
         code_reg <= 4'h0;
         cnt_reg <= 8'h00;
      end else begin
         cand_reg <= cand_next;
         code_reg <= code_next;
         cnt_reg <= cnt_next;
      end
   end

   assign o_code = code_reg;
endmodule

// ### bench/pwm_sva.sv
// checker: port timing checks for the divided pwm generator
`timescale 1ns/1ns
module pwm_sva
   import pwm_pkg::*;
#(
   parameter int START_CNT = START_TICKS
) (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_master_tick,
   input wire logic i_current_ok,
   input wire logic [CODE_W-1:0] i_ratio_selector_code,
   input wire logic [DUTY_W-1:0] i_duty_control_input,
   input wire logic o_pwm,
   input wire logic o_running,
   input wire logic [CODE_W-1:0] o_active_code
);
   int tick_reg;
   // ticks since reset, saturating so it never wraps
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) tick_reg <= 0;
      else if (i_master_tick && tick_reg < START_CNT) tick_reg <= tick_reg + 1;
   end
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_rst_n);
   chk_start_low: assert property (!o_running |-> !o_pwm)
      else $error("output active during start-up");
   chk_run_timing: assert property (o_running |-> tick_reg >= START_CNT)
      else $error("start-up ended too early");
   chk_run_sticky: assert property (o_running |=> o_running)
      else $error("running flag dropped");
   chk_pwm_on_tick: assert property ($changed(o_pwm) && $past(o_running)
      |-> $past(i_master_tick) || $past(i_master_tick, 2)) else $error("edge without tick");
   chk_code_held: assert property ($changed(o_active_code) && $past(o_running)
      |-> o_active_code == i_ratio_selector_code) else $error("code adopted unsettled");
   chk_freeze_out: assert property (!i_current_ok ##1 !i_current_ok |=> $stable(o_pwm))
      else $error("output moved without current");
   chk_run_code: assert property ($rose(o_running) |-> o_active_code == i_ratio_selector_code)
      else $error("wrong code at start");
   chk_rst_idle: assert property ($rose(i_rst_n) |-> !o_running [*8])
      else $error("running right after reset");
   cover property ($rose(o_running));
   cover property ($changed(o_active_code) && o_running);
   cover property ($fell(i_current_ok) && o_running);
endmodule
bind divided_pwm pwm_sva #(.START_CNT(START_CNT)) u_sva (.i_clock(i_clock),
   .i_rst_n(i_rst_n), .i_master_tick(i_master_tick), .i_current_ok(i_current_ok),
   .i_ratio_selector_code(i_ratio_selector_code), .i_duty_control_input(i_duty_control_input),
   .o_pwm(o_pwm), .o_running(o_running), .o_active_code(o_active_code));

// ### bench/setting_source.sv
// partner: board setting network and master oscillator feeding the pins
`timescale 1ns/1ns
module setting_source
   import pwm_pkg::*;
(
   input wire logic i_clock,
   input wire logic [CODE_W-1:0] i_code_want,
   input wire logic [DUTY_W-1:0] i_duty_want,
   output logic o_tick,
   output logic [CODE_W-1:0] o_code,
   output logic [DUTY_W-1:0] o_duty
);
   int div = 0;
   initial begin
      o_tick = 1'b0;
      o_code = 4'h0;
      o_duty = 8'h00;
   end
   // tick every 25 clocks is the 1MHz ceiling at this clock rate
   always @(negedge i_clock) begin
      div <= (div == 24) ? 0 : div + 1;
      o_tick <= (div == 24);
      o_code <= i_code_want;
      o_duty <= i_duty_want;
   end
endmodule

// ### bench/testbench.sv
// testbench: start-up, polarity, duty, filter and freeze checks, codes 0 and 15 only, both at ratio 1
`timescale 1ns/1ns
module testbench
   import pwm_pkg::*;
;
   logic i_clock = 0, i_rst_n = 0, i_current_ok = 1, tick, o_pwm, o_running, held;
   logic [3:0] code_want = 4'h0, code, o_active_code;
   logic [7:0] duty_want = 8'h80, duty;
   logic [8:0] hi;
   int fails = 0, total_checks = 0, cycles = 0;
   logic [3:0] t_code [4] = '{4'h0, 4'hF, 4'h0, 4'h0};
   logic [7:0] t_duty [4] = '{8'hFF, 8'h80, 8'h00, 8'h80};
   logic [8:0] t_hi [4] = '{9'h100, 9'h081, 9'h000, 9'h07F};
   initial begin
      forever #20 i_clock = ~i_clock;
   end
   // short start and filter counts keep the run brief
   divided_pwm #(.VARIANT(VARIANT_FULL), .START_CNT(5), .FILTER_CNT(2)) DUT (.i_clock(i_clock),
      .i_rst_n(i_rst_n), .i_master_tick(tick), .i_current_ok(i_current_ok),
      .i_ratio_selector_code(code), .i_duty_control_input(duty), .o_pwm(o_pwm),
      .o_running(o_running), .o_active_code(o_active_code));
   setting_source partner (.i_clock(i_clock), .i_code_want(code_want),
      .i_duty_want(duty_want), .o_tick(tick), .o_code(code), .o_duty(duty));
   // ends at a falling edge so outputs are settled and inputs may change
   task automatic wait_ticks(input int n);
      repeat (n) @(posedge i_clock iff tick);
      @(negedge i_clock);
   endtask
   task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask
   // high ticks over any 256 ticks, one full period at ratio 1, once settled
   task automatic measure(output logic [8:0] n);
      n = 9'h000;
      repeat (256) begin
         @(posedge i_clock iff tick);
         n = n + {8'h00, o_pwm};
      end
      @(negedge i_clock);
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 85000) begin
         fails++;
         wrap_up();
      end
   end
   initial begin
      repeat (12) @(negedge i_clock);
      i_rst_n <= 1'b1;
      wait_ticks(3);
      check({8'h00, o_running}, 9'h000, "early run");
      wait_ticks(4);
      check({8'h00, o_running}, 9'h001, "no run");
      for (int i = 0; i < 4; i++) begin
         code_want <= t_code[i];
         duty_want <= t_duty[i];
         wait_ticks(270);
         check({5'h00, o_active_code}, {5'h00, t_code[i]}, "code");
         measure(hi);
         check(hi, t_hi[i], "high ticks");
      end
      // a one-tick glitch must not be adopted
      code_want <= 4'h5;
      wait_ticks(1);
      code_want <= 4'h0;
      wait_ticks(270);
      check({5'h00, o_active_code}, 9'h000, "glitch");
      held = o_pwm;
      i_current_ok <= 1'b0;
      wait_ticks(50);
      check({8'h00, o_pwm}, {8'h00, held}, "freeze");
      i_current_ok <= 1'b1;
      wait_ticks(2);
      wrap_up();
   end
endmodule
